// ---- fsps_top.sv ----
// Purpose: flash self-programming sequencer with AXI4-Lite registers
// Assumes: core writes control, then store register, within the window
// Notes: flash array model is outside; this block drives its strobes
// Function
// - reset vector is 0x0000 when boot select fuse is 1, else boot address
// - fuses are inputs only; no software path changes them
// - pointer latched when an operation starts
// - lock-bit setting ignores the pointer
// - byte read uses pointer bit 0 to pick low or high byte
// - erase command 0000011 then store within four cycles erases the page
// - halt cpu while erasing or writing a halting-section page
// - load command then store writes data word at word-in-page slot
// - buffer cleared when a page write starts, on re-enable, and on reset
// - eeprom write during page loading discards the buffer
// - write command then store programs buffer into the page
// - interrupt held while enabled and self-program enable is clear
// - section busy set and reads blocked during erase or write
// - re-enable write clears the section busy flag
// - lock command programs lock bits whose data bits 5..0 are zero
// - lock programming neither halts cpu nor blocks reads
// - eeprom write blocks programming and lock reads
// - buffer accepts loads in any word order
// - application-section writes refused under write-protect lock mode
module fsps_top
  import fsps_pkg::*;
#(
  parameter int PAGE_WORDS_LOG2 = 5,
  parameter int PROG_CYCLES = FSPS_PROG_CYCLES,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'h3800,
  parameter logic [15:0] HALT_SECTION_START = 16'h3800
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // fuses and eeprom status, from other domains
  input wire logic boot_reset_select_fuse_i,
  input wire logic eeprom_write_busy_i,
  // core and flash side
  output logic [15:0] reset_vector_o,
  output logic cpu_halt_o,
  output logic rww_read_block_o,
  output logic irq_o,
  output logic flash_erase_o,
  output logic flash_write_o,
  output logic [15:0] flash_addr_o,
  output logic [5:0] lock_bits_o
);
  localparam int PW = PAGE_WORDS_LOG2;
  localparam int DEPTH = 1 << PW;
  localparam int CW = $clog2(PROG_CYCLES + 1);

  // refused at elaboration: the index slices below need 1..7
  if (PW < 1 || PW > 7) $error("page size out of range");
  if (PROG_CYCLES < 1) $error("program time too short");

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0] fuse_q, eew_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fuse_q <= 2'b11;
      eew_q <= 2'b00;
    end else begin
      fuse_q <= {fuse_q[0], boot_reset_select_fuse_i};
      eew_q <= {eew_q[0], eeprom_write_busy_i};
    end
  end
  wire logic fuse_s = fuse_q[1];
  wire logic eew_s = eew_q[1];

  // ----------------------------------------
  // bus write channel
  // ----------------------------------------
  logic aw_held_q, w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire logic wr_go = aw_held_q && w_held_q && !s_axi_bvalid_o;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= FSPS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_q <= 1'b1;
        s_axi_awready_o <= 1'b0;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_q <= 1'b1;
        s_axi_wready_o <= 1'b0;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_known(awaddr_q) ? FSPS_RESP_OKAY :
                         FSPS_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end
  // ready lines are flops, so the bus sees no logic path from here

  function automatic logic wr_known(input logic [7:0] a);
    wr_known = (a == FSPS_OFF_CTRL) || (a == FSPS_OFF_PTR) ||
               (a == FSPS_OFF_DATA) || (a == FSPS_OFF_STORE);
  endfunction

  wire logic wr_ctrl = wr_go && awaddr_q == FSPS_OFF_CTRL && wstrb_q[0];
  wire logic wr_store = wr_go && awaddr_q == FSPS_OFF_STORE;

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  logic [15:0] ptr_q;
  logic [15:0] data_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_q <= 16'h0000;
      data_q <= 16'h0000;
    end else if (wr_go) begin
      if (awaddr_q == FSPS_OFF_PTR) begin
        if (wstrb_q[0]) ptr_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) ptr_q[15:8] <= wdata_q[15:8];
      end
      if (awaddr_q == FSPS_OFF_DATA) begin
        if (wstrb_q[0]) data_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) data_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  fsps_state_e state_q;
  logic [6:0] cmd_q;
  logic ie_q;
  logic [2:0] win_q;
  logic [CW-1:0] cnt_q;
  logic busy_q;
  logic halt_q;
  logic erase_q, write_q;
  logic [15:0] addr_q;
  logic [5:0] lock_q;
  logic [15:0] buf_q [DEPTH];
  logic [DEPTH-1:0] buf_vld_q;
  logic loading_q;
  logic eew_d1_q;

  function automatic logic app_protected(input logic [5:0] lk);
    app_protected = !lk[1];
  endfunction

  wire logic [PW-1:0] word_idx = ptr_q[PW:1];
  wire logic [15:0] page_addr = {ptr_q[15:PW+1], {(PW+1){1'b0}}};
  wire logic in_halt = page_addr >= HALT_SECTION_START;
  // store inside the window with enable set; eeprom write blocks it
  wire logic go = state_q == FSPS_ARMED && wr_store && !eew_s;
  wire logic refused = (cmd_q == FSPS_CMD_ERASE || cmd_q == FSPS_CMD_WRITE)
                       && !in_halt && app_protected(lock_q);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= FSPS_IDLE;
      cmd_q <= 7'h00;
      ie_q <= 1'b0;
      win_q <= 3'd0;
      cnt_q <= '0;
      halt_q <= 1'b0;
      erase_q <= 1'b0;
      write_q <= 1'b0;
      addr_q <= 16'h0000;
    end else begin
      erase_q <= 1'b0;
      write_q <= 1'b0;
      if (wr_ctrl) ie_q <= wdata_q[FSPS_BIT_IE];
      case (state_q)
        FSPS_IDLE: begin
          if (wr_ctrl && wdata_q[FSPS_BIT_EN] && !eew_s) begin
            cmd_q <= wdata_q[6:0];
            win_q <= 3'(FSPS_STORE_WINDOW);
            state_q <= FSPS_ARMED;
          end
        end
        FSPS_ARMED: begin
          if (go) begin
            if (cmd_q == FSPS_CMD_LOAD || cmd_q == FSPS_CMD_REEN ||
                refused) begin
              cmd_q <= 7'h00;
              state_q <= FSPS_IDLE;
            end else begin
              addr_q <= page_addr;
              erase_q <= cmd_q == FSPS_CMD_ERASE;
              write_q <= cmd_q == FSPS_CMD_WRITE;
              halt_q <= cmd_q != FSPS_CMD_LOCK && in_halt;
              cnt_q <= CW'(PROG_CYCLES);
              state_q <= FSPS_PROG;
            end
          end else if (win_q == 3'd1) begin
            cmd_q <= 7'h00;
            state_q <= FSPS_IDLE;
          end else begin
            win_q <= win_q - 3'd1;
          end
        end
        FSPS_PROG: begin
          if (cnt_q == CW'(1)) begin
            cmd_q <= 7'h00;
            halt_q <= 1'b0;
            state_q <= FSPS_IDLE;
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        default: state_q <= FSPS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // section busy flag
  // ----------------------------------------
  wire logic reen_go = go && cmd_q == FSPS_CMD_REEN;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
    end else if (state_q == FSPS_ARMED && go && !refused &&
                 (cmd_q == FSPS_CMD_ERASE || cmd_q == FSPS_CMD_WRITE)) begin
      busy_q <= 1'b1;
    end else if (reen_go && state_q != FSPS_PROG) begin
      busy_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // lock bits: programming only clears, never sets
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_q <= FSPS_LOCK_RESET;
    end else if (go && cmd_q == FSPS_CMD_LOCK) begin
      lock_q <= lock_q & data_q[5:0];
    end
  end

  // ----------------------------------------
  // temporary page buffer
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf_vld_q <= '0;
      loading_q <= 1'b0;
      eew_d1_q <= 1'b0;
    end else begin
      eew_d1_q <= eew_s;
      if (write_q || reen_go) begin
        buf_vld_q <= '0;
        loading_q <= 1'b0;
      end else if (eew_s && !eew_d1_q && loading_q) begin
        buf_vld_q <= '0;
        loading_q <= 1'b0;
      end else if (go && cmd_q == FSPS_CMD_LOAD) begin
        buf_vld_q[word_idx] <= 1'b1;
        loading_q <= 1'b1;
      end
    end
  end
  // data array holds no control state, so it has no reset
  always_ff @(posedge ref_clk_i) begin
    if (go && cmd_q == FSPS_CMD_LOAD) buf_q[word_idx] <= data_q;
  end

  // ----------------------------------------
  // bus read channel
  // ----------------------------------------
  logic [PW:0] rd_byte;
  logic [15:0] rd_word;
  always_comb begin
    rd_byte = ptr_q[PW:0];
    rd_word = buf_vld_q[rd_byte[PW:1]] ? buf_q[rd_byte[PW:1]] : 16'hFFFF;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= FSPS_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_arready_o <= 1'b0;
      s_axi_rresp_o <= FSPS_RESP_OKAY;
      case (s_axi_araddr_i)
        FSPS_OFF_CTRL: s_axi_rdata_o <= {24'h0, ie_q, busy_q, 1'b0,
                                         cmd_q[4:0]};
        FSPS_OFF_PTR: s_axi_rdata_o <= {16'h0, ptr_q};
        FSPS_OFF_DATA: s_axi_rdata_o <= {16'h0, data_q};
        FSPS_OFF_STATUS: s_axi_rdata_o <= {29'h0, eew_s, halt_q, busy_q};
        // lock readback refused while eeprom is busy
        FSPS_OFF_LOCK: s_axi_rdata_o <= eew_s ? 32'h0 :
                                        {26'h0, lock_q};
        FSPS_OFF_RDBUF: s_axi_rdata_o <= {24'h0, rd_byte[0] ?
                                          rd_word[15:8] : rd_word[7:0]};
        default: begin
          s_axi_rdata_o <= 32'h0;
          s_axi_rresp_o <= FSPS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ----------------------------------------
  // core-facing outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_vector_o <= FSPS_APP_RESET_ADDR;
      cpu_halt_o <= 1'b0;
      rww_read_block_o <= 1'b0;
      irq_o <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      flash_addr_o <= 16'h0000;
      lock_bits_o <= FSPS_LOCK_RESET;
    end else begin
      // fuse is read only, so the vector simply follows it
      reset_vector_o <= fuse_s ? FSPS_APP_RESET_ADDR :
                        BOOT_RESET_ADDR;
      cpu_halt_o <= halt_q;
      rww_read_block_o <= busy_q;
      irq_o <= ie_q && state_q == FSPS_IDLE;
      flash_erase_o <= erase_q;
      flash_write_o <= write_q;
      flash_addr_o <= addr_q;
      lock_bits_o <= lock_q;
    end
  end
endmodule

// ---- fsps_pkg.sv ----
// Purpose: constants for the flash self-programming sequencer
// Assumes: 40 MHz core clock, 32-bit AXI4-Lite register access
// Notes: offsets are byte addresses of aligned words
package fsps_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] FSPS_OFF_CTRL = 8'h00;
  localparam logic [7:0] FSPS_OFF_PTR = 8'h04;
  localparam logic [7:0] FSPS_OFF_DATA = 8'h08;
  localparam logic [7:0] FSPS_OFF_STORE = 8'h0C;
  localparam logic [7:0] FSPS_OFF_STATUS = 8'h10;
  localparam logic [7:0] FSPS_OFF_LOCK = 8'h14;
  localparam logic [7:0] FSPS_OFF_RDBUF = 8'h18;
  // ----------------------------------------
  // control/status field positions
  // ----------------------------------------
  localparam int FSPS_BIT_EN = 0;
  localparam int FSPS_BIT_ERASE = 1;
  localparam int FSPS_BIT_WRITE = 2;
  localparam int FSPS_BIT_LOCKSEL = 3;
  localparam int FSPS_BIT_REEN = 4;
  localparam int FSPS_BIT_BUSY = 6;
  localparam int FSPS_BIT_IE = 7;
  // ----------------------------------------
  // command codes, bits 6..0 (bit 7 ignored)
  // ----------------------------------------
  localparam logic [6:0] FSPS_CMD_LOAD = 7'h01;
  localparam logic [6:0] FSPS_CMD_ERASE = 7'h03;
  localparam logic [6:0] FSPS_CMD_WRITE = 7'h05;
  localparam logic [6:0] FSPS_CMD_LOCK = 7'h09;
  localparam logic [6:0] FSPS_CMD_REEN = 7'h11;
  // ----------------------------------------
  // timing and reset values
  // ----------------------------------------
  localparam int FSPS_STORE_WINDOW = 4;
  localparam logic [15:0] FSPS_APP_RESET_ADDR = 16'h0000;
  localparam logic [5:0] FSPS_LOCK_RESET = 6'h3F;
  localparam int FSPS_PROG_TIME_US = 4;
  localparam int FSPS_CLK_MHZ = 40;
  localparam int FSPS_PROG_CYCLES = FSPS_PROG_TIME_US * FSPS_CLK_MHZ;
  localparam logic [1:0] FSPS_RESP_OKAY = 2'b00;
  localparam logic [1:0] FSPS_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {FSPS_IDLE, FSPS_ARMED, FSPS_PROG} fsps_state_e;
endpackage

// ---- fsps_monitor.sv ----
// Purpose: port-level checks of the self-programming sequencer
// Assumes: bound to fsps_top, one clock domain
// Notes: the bus itself is checked by the bench
module fsps_monitor
  import fsps_pkg::*;
#(
  parameter int PAGE_WORDS_LOG2 = 5,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'h3800,
  parameter logic [15:0] HALT_SECTION_START = 16'h3800
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // watched pins
  input wire logic boot_reset_select_fuse_i,
  input wire logic eeprom_write_busy_i,
  input wire logic [15:0] reset_vector_o,
  input wire logic cpu_halt_o,
  input wire logic rww_read_block_o,
  input wire logic irq_o,
  input wire logic flash_erase_o,
  input wire logic flash_write_o,
  input wire logic [15:0] flash_addr_o,
  input wire logic [5:0] lock_bits_o
);
  // ----
  // properties
  // ----
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] low_mask;
  assign low_mask = (16'h1 << (PAGE_WORDS_LOG2 + 1)) - 16'h1;
  sequence prog_start;
    flash_erase_o || flash_write_o;
  endsequence
  sequence prog_high;
    prog_start ##0 (flash_addr_o >= HALT_SECTION_START);
  endsequence
  chk_halt_start: assert property (
    prog_high |-> ##[0:2] cpu_halt_o) else $error("no halt on high page");
  chk_low_nohalt: assert property (
    flash_addr_o < HALT_SECTION_START |-> !cpu_halt_o)
    else $error("halt on low page");
  chk_busy_start: assert property (
    prog_start |-> ##[0:2] rww_read_block_o) else $error("busy not set");
  chk_halt_busy: assert property (
    cpu_halt_o && $past(cpu_halt_o) |-> rww_read_block_o)
    else $error("halt without busy");
  chk_addr_align: assert property (
    prog_start |-> (flash_addr_o & low_mask) == 16'h0000)
    else $error("page address not aligned");
  chk_addr_hold: assert property (
    cpu_halt_o && $past(cpu_halt_o) |-> $stable(flash_addr_o))
    else $error("address moved mid operation");
  chk_lock_clear: assert property (
    (lock_bits_o & ~$past(lock_bits_o)) == 6'h00)
    else $error("lock bit went back to one");
  chk_vec_app: assert property (
    boot_reset_select_fuse_i [*4] |-> reset_vector_o == 16'h0000)
    else $error("wrong application vector");
  chk_vec_boot: assert property (
    !boot_reset_select_fuse_i [*4] |-> reset_vector_o == BOOT_RESET_ADDR)
    else $error("wrong boot vector");
  chk_ee_block: assert property (
    eeprom_write_busy_i [*5] |-> !(flash_erase_o || flash_write_o))
    else $error("flash started during eeprom write");
  chk_irq_idle: assert property (
    irq_o |-> !cpu_halt_o) else $error("interrupt while running");
endmodule

// ---- fsps_eeprom_model.sv ----
// Purpose: eeprom controller beside the sequencer, busy after a start
// Assumes: start is a one-cycle pulse from the bench
// Notes: busy length is long enough to cover a whole command sequence
module fsps_eeprom_model #(
  parameter int BUSY_CYCLES = 60
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic start_i,
  output logic busy_o
);
  int cnt_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 0;
    end else if (start_i) begin
      cnt_q <= BUSY_CYCLES;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign busy_o = (cnt_q != 0);
endmodule

// ---- testbench.sv ----
// Purpose: register-level test of the self-programming sequencer
// Assumes: PROG_CYCLES shortened to 8
// Notes: bready and rready stay high, so answers are taken at once
module testbench
  import fsps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, ee_go = 1'b0;
  logic s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd_v;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic boot_reset_select_fuse_i = 1'b1, eeprom_write_busy_i;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
  logic [15:0] reset_vector_o, flash_addr_o;
  logic cpu_halt_o, rww_read_block_o, irq_o, flash_erase_o, flash_write_o;
  logic [5:0] lock_bits_o;
  int n_errors = 0, comparisons = 0, cyc = 0;
  int n_ers = 0, n_wrs = 0;
  fsps_top #(.PROG_CYCLES(8)) i_fsps_top (.*);
  fsps_eeprom_model i_fsps_eeprom_model (.clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .start_i(ee_go), .busy_o(eeprom_write_busy_i));
  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // ----
  // tasks
  // ----
  task close_out;
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // address and data offered together, each dropped when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    while (pa || pw) begin
      @(posedge ref_clk_i);
      if (pa && s_axi_awready_o === 1'b1) begin
        pa = 1'b0;
        s_axi_awvalid_i <= 1'b0;
      end
      if (pw && s_axi_wready_o === 1'b1) begin
        pw = 1'b0;
        s_axi_wvalid_i <= 1'b0;
      end
    end
    do @(posedge ref_clk_i); while (s_axi_bvalid_o !== 1'b1);
    rs = s_axi_bresp_o;
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do @(posedge ref_clk_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge ref_clk_i); while (s_axi_rvalid_o !== 1'b1);
    rd_v = s_axi_rdata_o;
    rs = s_axi_rresp_o;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_v, exp);
  endtask
  // store must be the very next write after the command
  task spm(input logic [15:0] p, input logic [15:0] d, input logic [7:0] c);
    wr(FSPS_OFF_PTR, {16'h0, p});
    wr(FSPS_OFF_DATA, {16'h0, d});
    wr(FSPS_OFF_CTRL, {24'h0, c});
    wr(FSPS_OFF_STORE, 32'h0);
  endtask
  task idle;
    for (int i = 0; i < 20; i++) begin
      rd(FSPS_OFF_CTRL);
      if (rd_v[0] === 1'b0) break;
    end
  endtask
  task reset_pulse;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
  endtask
  // strobes stand one cycle, so they are counted as they pass
  always @(posedge ref_clk_i) begin
    if (flash_erase_o === 1'b1) n_ers++;
    if (flash_write_o === 1'b1) n_wrs++;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      close_out;
    end
  end
  // ----
  // sequence
  // ----
  initial begin
    reset_pulse;
    chk(lock_bits_o, 32'h3F);
    chk(reset_vector_o, 32'h0);
    rdchk(FSPS_OFF_RDBUF, 32'hFF);
    spm(16'h3846, 16'hA55A, 8'h01);
    spm(16'h3842, 16'h1234, 8'h01);
    wr(FSPS_OFF_PTR, 32'h3847);
    rdchk(FSPS_OFF_RDBUF, 32'hA5);
    wr(FSPS_OFF_PTR, 32'h3842);
    rdchk(FSPS_OFF_RDBUF, 32'h34);
    spm(16'h3846, 16'hFFFF, 8'h03);
    // same word slot on another page: the erase keeps its latched page
    wr(FSPS_OFF_PTR, 32'h3806);
    @(posedge ref_clk_i);
    chk(flash_addr_o, 32'h3840);
    chk(cpu_halt_o, 32'h1);
    chk(rww_read_block_o, 32'h1);
    idle;
    rdchk(FSPS_OFF_STATUS, 32'h1);
    rdchk(FSPS_OFF_CTRL, 32'h40);
    rdchk(FSPS_OFF_RDBUF, 32'h5A);
    spm(16'h3840, 16'h0000, 8'h05);
    idle;
    wr(FSPS_OFF_PTR, 32'h3846);
    rdchk(FSPS_OFF_RDBUF, 32'hFF);
    spm(16'h3846, 16'h7777, 8'h01);
    spm(16'h3846, 16'h0000, 8'h11);
    idle;
    chk(rww_read_block_o, 32'h0);
    rdchk(FSPS_OFF_RDBUF, 32'hFF);
    wr(FSPS_OFF_CTRL, 32'h01);
    wr(FSPS_OFF_DATA, 32'h1111);
    wr(FSPS_OFF_STORE, 32'h0);
    rdchk(FSPS_OFF_RDBUF, 32'hFF);
    rdchk(FSPS_OFF_CTRL, 32'h00);
    wr(FSPS_OFF_STORE, 32'h0);
    rdchk(FSPS_OFF_RDBUF, 32'hFF);
    // erase bit without enable, then store at once: nothing may start
    wr(FSPS_OFF_CTRL, 32'h02);
    wr(FSPS_OFF_STORE, 32'h0);
    @(posedge ref_clk_i);
    chk(rww_read_block_o, 32'h0);
    wr(FSPS_OFF_CTRL, 32'h80);
    @(posedge ref_clk_i);
    chk(irq_o, 32'h1);
    wr(FSPS_OFF_CTRL, 32'h00);
    @(posedge ref_clk_i);
    chk(irq_o, 32'h0);
    // pointer left off the advised value to show it is ignored
    spm(16'hBEEF, 16'h00FD, 8'h09);
    @(posedge ref_clk_i);
    chk(cpu_halt_o, 32'h0);
    chk(rww_read_block_o, 32'h0);
    idle;
    chk(lock_bits_o, 32'h3D);
    rdchk(FSPS_OFF_LOCK, 32'h3D);
    spm(16'h0100, 16'h0000, 8'h03);
    @(posedge ref_clk_i);
    chk(rww_read_block_o, 32'h0);
    rdchk(FSPS_OFF_STATUS, 32'h0);
    spm(16'h3846, 16'hABCD, 8'h01);
    ee_go <= 1'b1;
    @(posedge ref_clk_i);
    ee_go <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    spm(16'h3846, 16'h00FE, 8'h09);
    @(posedge ref_clk_i);
    chk(lock_bits_o, 32'h3D);
    rdchk(FSPS_OFF_LOCK, 32'h0);
    rdchk(FSPS_OFF_STATUS, 32'h4);
    rdchk(FSPS_OFF_RDBUF, 32'hFF);
    // mid-run reset, also clears the eeprom model
    reset_pulse;
    spm(16'h3846, 16'h2468, 8'h01);
    rdchk(FSPS_OFF_RDBUF, 32'h68);
    reset_pulse;
    wr(FSPS_OFF_PTR, 32'h3846);
    rdchk(FSPS_OFF_RDBUF, 32'hFF);
    boot_reset_select_fuse_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    chk(reset_vector_o, 32'h3800);
    wr(8'h1C, 32'h0);
    chk(rs, FSPS_RESP_SLVERR);
    rd(8'h20);
    chk(rd_v, 32'h0);
    chk(rs, FSPS_RESP_SLVERR);
    chk(n_ers, 32'h1);
    chk(n_wrs, 32'h1);
    close_out;
  end
endmodule
bind fsps_top fsps_monitor #(.PAGE_WORDS_LOG2(PAGE_WORDS_LOG2),
  .BOOT_RESET_ADDR(BOOT_RESET_ADDR),
  .HALT_SECTION_START(HALT_SECTION_START)) i_fsps_monitor (.*);
